/* hdl/apit_consts.vh */
// Purpose: constants for the periodic interrupt timer
// Assumes: apb word addressing, register indices below
// Notes: offsets not all multiples of four, so they are register indices
`ifndef APIT_CONSTS_VH
`define APIT_CONSTS_VH
`define APIT_IDX_CTL 12'h2F2
`define APIT_IDX_TRIM 12'h2F3
`define APIT_IDX_RATEH 12'h2F4
`define APIT_IDX_RATEL 12'h2F5
`define APIT_IDX_INTMASK 12'h2F6
`define APIT_IDX_INTSTAT 12'h2F7
`define APIT_CTL_SRC 7
`define APIT_CTL_WAVE 4
`define APIT_CTL_PINEN 3
`define APIT_CTL_FE 2
`define APIT_CTL_IE 1
`define APIT_CTL_FLAG 0
`define APIT_TRIM_LSB 2
`define APIT_RESET_CTL 8'h00
`define APIT_RESET_RATE 16'h0000
`define APIT_SLOW_HZ 10000
`define APIT_CLK_HZ 25000000
`define APIT_SLOW_BASE_CYC (`APIT_CLK_HZ / `APIT_SLOW_HZ)
`endif

/* hdl/apit_timer.v */
// Purpose: autonomous periodic interrupt timer with apb registers
// Assumes: one clock pclk at 25 MHz; slow clock made by a trimmed divider
// Notes: register byte address is four times the printed index
`include "apit_consts.vh"
module apit_timer #(
  parameter SLOW_BASE = `APIT_SLOW_BASE_CYC,
  parameter [5:0] TRIM_STORED = 6'h00
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // timer
  output reg timer_wave_pin,
  output wire timer_wave_pin_oe,
  output wire irq
);
  localparam ST_LOAD = 2'b01;
  localparam ST_RUN = 2'b10;
  // base must stay below 2^20 - 768 cycles
  localparam [19:0] SLOW_BASE_W = SLOW_BASE[19:0];

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] ctl_ff;
  reg [7:0] nxt_ctl;
  reg [5:0] trim_ff;
  reg [5:0] nxt_trim;
  reg [15:0] rate_ff;
  reg [15:0] nxt_rate;
  reg [1:0] mask_ff;
  reg [1:0] nxt_mask;
  reg [1:0] stat_ff;
  reg [1:0] nxt_stat;
  reg [19:0] slow_cnt_ff;
  reg [19:0] nxt_slow_cnt;
  reg [16:0] half_cnt_ff;
  reg [16:0] nxt_half_cnt;
  reg phase_ff;
  reg nxt_phase;
  reg [19:0] pulse_cnt_ff;
  reg [19:0] nxt_pulse_cnt;
  reg pulse_ff;
  reg nxt_pulse;
  reg clkwave_ff;
  reg nxt_clkwave;
  reg nxt_wave_pin;
  reg [31:0] nxt_prdata;

  wire [11:0] idx;
  wire acc;
  wire wr;
  wire rd_setup;
  wire fe;
  wire src_bus;
  wire addr_ok;
  wire wr_ctl;
  wire wr_trim;
  wire wr_rateh;
  wire wr_ratel;
  wire wr_mask;
  wire wr_stat;
  wire en_event;
  wire pin_on;
  wire [19:0] trim_cut;
  wire [19:0] trim_add;
  wire [20:0] slow_sum;
  wire [20:0] slow_len_w;
  wire [19:0] slow_len;
  wire slow_tick;
  wire tick;
  wire half_end;
  wire timeout;
  wire [19:0] min_half;

  assign idx = paddr[13:2];
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  // read data is caught in the setup cycle so it stands in a flop
  assign rd_setup = psel & ~penable & ~pwrite;
  assign fe = ctl_ff[`APIT_CTL_FE];
  assign src_bus = ctl_ff[`APIT_CTL_SRC];
  assign addr_ok = (idx >= `APIT_IDX_CTL) && (idx <= `APIT_IDX_INTSTAT) &&
    (paddr[1:0] == 2'b00);
  assign wr_ctl = wr && (idx == `APIT_IDX_CTL);
  assign wr_trim = wr && (idx == `APIT_IDX_TRIM);
  assign wr_rateh = wr && (idx == `APIT_IDX_RATEH);
  assign wr_ratel = wr && (idx == `APIT_IDX_RATEL);
  assign wr_mask = wr && (idx == `APIT_IDX_INTMASK);
  assign wr_stat = wr && (idx == `APIT_IDX_INTSTAT);
  assign en_event = wr_ctl & pwdata[`APIT_CTL_FE] & ~fe;
  assign pin_on = fe & ctl_ff[`APIT_CTL_PINEN];

  assign pready = 1'b1;
  assign pslverr = acc & ~addr_ok;

  // bit5 lengthens by more than all lower bits together shorten
  assign trim_cut = {12'h000, trim_ff[4:0], 3'b000};
  assign trim_add = trim_ff[5] ? 20'h00300 : 20'h00000;
  assign slow_sum = {1'b0, SLOW_BASE_W} + {1'b0, trim_add};
  assign slow_len_w = slow_sum - {1'b0, trim_cut};
  // an underflow clamps to one cycle rather than wrapping
  assign slow_len = (slow_len_w[20] || slow_len_w[19:0] == 20'h00000) ?
    20'h00001 : slow_len_w[19:0];

  assign slow_tick = (slow_cnt_ff >= slow_len - 20'h00001);
  assign tick = src_bus ? 1'b1 : slow_tick;
  // half period ends after rate+1 ticks; two halves per timeout
  assign half_end = fe & tick & (half_cnt_ff == {1'b0, rate_ff});
  assign timeout = half_end & phase_ff;
  assign min_half = src_bus ? 20'h00001 : slow_len;

  assign timer_wave_pin_oe = pin_on;
  // flag request gated by enable, plus masked status events
  assign irq = (ctl_ff[`APIT_CTL_IE] & ctl_ff[`APIT_CTL_FLAG]) |
    (|(stat_ff & mask_ff));

  // slow clock divider runs free so the source is autonomous
  always @* begin
    if (slow_tick) begin
      nxt_slow_cnt = 20'h00000;
    end else begin
      nxt_slow_cnt = slow_cnt_ff + 20'h00001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt_ff <= 20'h00000;
    end else begin
      slow_cnt_ff <= nxt_slow_cnt;
    end
  end

  // period counter
  always @* begin
    nxt_half_cnt = half_cnt_ff;
    nxt_phase = phase_ff;
    if (!fe) begin
      nxt_half_cnt = 17'h00000;
      nxt_phase = 1'b0;
    end else if (half_end) begin
      nxt_half_cnt = 17'h00000;
      nxt_phase = ~phase_ff;
    end else if (tick) begin
      nxt_half_cnt = half_cnt_ff + 17'h00001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_ff <= 17'h00000;
      phase_ff <= 1'b0;
    end else begin
      half_cnt_ff <= nxt_half_cnt;
      phase_ff <= nxt_phase;
    end
  end

  // pin waveforms
  always @* begin
    nxt_pulse = pulse_ff;
    nxt_pulse_cnt = pulse_cnt_ff;
    nxt_clkwave = clkwave_ff;
    if (!fe) begin
      nxt_pulse = 1'b0;
      nxt_clkwave = 1'b0;
    end else if (timeout) begin
      nxt_pulse = 1'b1;
      nxt_pulse_cnt = 20'h00000;
      nxt_clkwave = ~clkwave_ff;
    end else if (pulse_ff) begin
      if (pulse_cnt_ff >= min_half - 20'h00001) begin
        nxt_pulse = 1'b0;
      end
      nxt_pulse_cnt = pulse_cnt_ff + 20'h00001;
    end
  end

  always @* begin
    nxt_wave_pin = 1'b0;
    if (pin_on) begin
      if (ctl_ff[`APIT_CTL_WAVE]) begin
        nxt_wave_pin = clkwave_ff;
      end else begin
        nxt_wave_pin = pulse_ff;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_ff <= 1'b0;
      pulse_cnt_ff <= 20'h00000;
    end else begin
      pulse_ff <= nxt_pulse;
      pulse_cnt_ff <= nxt_pulse_cnt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkwave_ff <= 1'b0;
    end else begin
      clkwave_ff <= nxt_clkwave;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_wave_pin <= 1'b0;
    end else begin
      timer_wave_pin <= nxt_wave_pin;
    end
  end

  // trim load sequencer
  always @* begin
    case (state_ff)
      ST_LOAD: nxt_state = ST_RUN;
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  // a trim write in the load cycle is lost to the stored value
  always @* begin
    nxt_trim = trim_ff;
    case (state_ff)
      ST_LOAD: begin
        nxt_trim = TRIM_STORED;
      end
      ST_RUN: begin
        if (wr_trim) begin
          nxt_trim = pwdata[7:2];
        end
      end
      default: begin
        nxt_trim = trim_ff;
      end
    endcase
  end

  always @* begin
    nxt_ctl = ctl_ff;
    if (wr_ctl) begin
      nxt_ctl[6:5] = 2'b00;
      nxt_ctl[`APIT_CTL_WAVE] = pwdata[`APIT_CTL_WAVE];
      nxt_ctl[`APIT_CTL_PINEN] = pwdata[`APIT_CTL_PINEN];
      nxt_ctl[`APIT_CTL_FE] = pwdata[`APIT_CTL_FE];
      nxt_ctl[`APIT_CTL_IE] = pwdata[`APIT_CTL_IE];
      // the enabling write itself may not move the source
      if (!fe && !pwdata[`APIT_CTL_FE]) begin
        nxt_ctl[`APIT_CTL_SRC] = pwdata[`APIT_CTL_SRC];
      end
    end
    // set wins over a write-one clear
    if (timeout) begin
      nxt_ctl[`APIT_CTL_FLAG] = 1'b1;
    end else if (wr_ctl && pwdata[`APIT_CTL_FLAG]) begin
      nxt_ctl[`APIT_CTL_FLAG] = 1'b0;
    end
  end

  always @* begin
    nxt_rate = rate_ff;
    if (wr_rateh && !fe) begin
      nxt_rate[15:8] = pwdata[7:0];
    end
    if (wr_ratel && !fe) begin
      nxt_rate[7:0] = pwdata[7:0];
    end
  end

  always @* begin
    nxt_mask = mask_ff;
    if (wr_mask) begin
      nxt_mask = pwdata[1:0];
    end
  end

  // status events win over a write-one clear
  always @* begin
    nxt_stat = stat_ff;
    if (wr_stat && pwdata[0]) begin
      nxt_stat[0] = 1'b0;
    end
    if (wr_stat && pwdata[1]) begin
      nxt_stat[1] = 1'b0;
    end
    if (timeout) begin
      nxt_stat[0] = 1'b1;
    end
    if (en_event) begin
      nxt_stat[1] = 1'b1;
    end
  end

  always @* begin
    nxt_prdata = 32'h00000000;
    if (rd_setup) begin
      case (idx)
        `APIT_IDX_CTL: nxt_prdata = {24'h000000, ctl_ff};
        `APIT_IDX_TRIM: nxt_prdata = {24'h000000, trim_ff, 2'b00};
        `APIT_IDX_RATEH: nxt_prdata = {24'h000000, rate_ff[15:8]};
        `APIT_IDX_RATEL: nxt_prdata = {24'h000000, rate_ff[7:0]};
        `APIT_IDX_INTMASK: nxt_prdata = {30'h00000000, mask_ff};
        `APIT_IDX_INTSTAT: nxt_prdata = {30'h00000000, stat_ff};
        default: nxt_prdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= `APIT_RESET_CTL;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_ff <= 6'h00;
    end else begin
      trim_ff <= nxt_trim;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_ff <= `APIT_RESET_RATE;
    end else begin
      rate_ff <= nxt_rate;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= 2'b00;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= 2'b00;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= nxt_prdata;
    end
  end
endmodule

/* test/apit_timer_sva.sv */
// Purpose: port checks of apit_timer
// Assumes: zero wait apb
// Notes: bound below
`include "apit_consts.vh"
module apit_chk (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // timer
  input wire timer_wave_pin,
  input wire timer_wave_pin_oe,
  input wire irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire [11:0] idx = paddr[13:2];
  wire mapd = idx >= `APIT_IDX_CTL && idx <= `APIT_IDX_INTSTAT && paddr[1:0] == 2'b00;
  wire ctl_w = acc && pwrite && idx == `APIT_IDX_CTL;
  sequence ctl_wr;
    ctl_w;
  endsequence
  AST_RDY: assert property (pready) else $error("pready low");
  AST_IDLE: assert property (!psel |-> prdata == 32'h0) else $error("prdata idle");
  AST_WRQ: assert property (psel && pwrite |-> prdata == 32'h0) else $error("prdata wr");
  AST_ERR: assert property (acc && !mapd |-> pslverr) else $error("no slverr");
  AST_OK: assert property (acc && mapd |-> !pslverr) else $error("bad slverr");
  AST_OE_ON: assert property (ctl_wr ##0 pwdata[3:2] == 2'h3 |=> timer_wave_pin_oe)
    else $error("pin not on");
  AST_OE_OFF: assert property (ctl_wr ##0 !pwdata[2] |=> !timer_wave_pin_oe [*2])
    else $error("pin not off");
  AST_OE_CHG: assert property ($changed(timer_wave_pin_oe) |-> $past(ctl_w))
    else $error("pin enable moved");
endmodule
bind apit_timer apit_chk apit_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_wave_pin(timer_wave_pin),
  .timer_wave_pin_oe(timer_wave_pin_oe), .irq(irq));

/* test/apit_timer_tb_top.sv */
// Purpose: bench of apit_timer
// Assumes: bus tick source at rate 3, slow source at rate 0 with base 200
// Notes: nonzero stored trim
`include "apit_consts.vh"
module apit_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
  logic [31:0] paddr = 0, pwdata = 0;
  logic [7:0] rd;
  wire [31:0] prdata;
  wire pready, pslverr, pin, oe, irq;
  int err_total = 0, num_checks = 0;
  apit_timer #(.SLOW_BASE(200), .TRIM_STORED(6'h15)) apit_timer_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_wave_pin(pin), .timer_wave_pin_oe(oe), .irq(irq));
  initial forever #20 pclk = ~pclk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // starts on a rising edge, ends mid cycle so callers see settled outputs
  task apb(input logic w, input logic [11:0] i, input logic [7:0] d);
    logic ok;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {18'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(negedge pclk);
      ok = pready;
      rd = prdata[7:0];
      se = pslverr;
      @(posedge pclk);
    end while (ok !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(negedge pclk);
  endtask
  task meas(output int h, output int r);
    h = 0;
    while (pin !== 1'b1) @(negedge pclk);
    while (pin === 1'b1) begin
      h++;
      @(negedge pclk);
    end
    r = h;
    while (pin !== 1'b1) begin
      r++;
      @(negedge pclk);
    end
  endtask
  task t_reset;
    apb(0, `APIT_IDX_CTL, 0);
    chk({rd, oe, pin, irq}, 11'h0);
    apb(0, `APIT_IDX_TRIM, 0);
    chk(rd[7:2], 6'h15);
    apb(1, `APIT_IDX_TRIM, 8'hA8);
    apb(0, `APIT_IDX_TRIM, 0);
    chk(rd, 8'hA8);
    $display("reset test done");
  endtask
  task t_wave;
    int h0, r0, h1, r1;
    apb(1, `APIT_IDX_RATEL, 8'h03);
    apb(1, `APIT_IDX_CTL, 8'h80);
    apb(1, `APIT_IDX_CTL, 8'h8E);
    meas(h0, r0);
    apb(1, `APIT_IDX_CTL, 8'h80);
    apb(1, `APIT_IDX_CTL, 8'h9E);
    meas(h1, r1);
    chk(r0 + r1, 24);
    chk(h0 + h1, 9);
    $display("wave test done");
  endtask
  task t_flag;
    apb(1, `APIT_IDX_RATEL, 8'h00);
    apb(1, `APIT_IDX_CTL, 8'h1E);
    apb(0, `APIT_IDX_RATEL, 0);
    chk(rd, 8'h03);
    apb(0, `APIT_IDX_CTL, 0);
    chk({rd[7], rd[0], irq}, 3'h7);
    apb(1, `APIT_IDX_CTL, 8'h80);
    chk({oe, irq}, 2'h0);
    apb(0, `APIT_IDX_CTL, 0);
    chk(rd, 8'h81);
    apb(1, `APIT_IDX_CTL, 8'h81);
    apb(0, `APIT_IDX_CTL, 0);
    chk(rd, 8'h80);
    apb(1, `APIT_IDX_INTMASK, 8'h01);
    chk(irq, 1'b1);
    apb(1, `APIT_IDX_INTSTAT, 8'h01);
    chk(irq, 1'b0);
    apb(0, 12'h100, 0);
    chk({se, rd}, 9'h100);
    $display("flag test done");
  endtask
  task t_slow;
    int h, r;
    apb(1, `APIT_IDX_CTL, 8'h00);
    apb(1, `APIT_IDX_TRIM, 8'h54);
    apb(1, `APIT_IDX_RATEL, 8'h00);
    apb(1, `APIT_IDX_CTL, 8'h0C);
    meas(h, r);
    chk(h, 32);
    chk(r, 64);
    apb(1, `APIT_IDX_CTL, 8'h00);
    apb(1, `APIT_IDX_TRIM, 8'h80);
    apb(1, `APIT_IDX_CTL, 8'h0C);
    meas(h, r);
    chk(h, 968);
    chk(r, 1936);
    $display("slow test done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    t_reset;
    t_wave;
    t_flag;
    t_slow;
    close_out;
  end
  initial begin
    #1000000;
    err_total++;
    close_out;
  end
endmodule
